// [hw/drive_terminal_logic.sv]
// module: terminal logic top, registers, input decode and logic outputs
`timescale 1ns/1ps
`default_nettype none
module drive_terminal_logic
  import drive_terminal_pkg::*;
#(
  parameter int FILTER_CYC = FILTER_UNIT_CYC,
  parameter int SETTLE_CYC = SETTLE_UNIT_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // terminals
  input wire logic [NUM_INPUTS-1:0] term_i,
  input wire logic [NUM_DOUT_FUNCS-1:0] dout_func_i,
  // results
  output logic [NUM_LOGIC-1:0] logic_out_o,
  output logic forward_run_input_o,
  output logic reverse_run_input_o,
  output logic jog_input_o,
  output logic external_dc_brake_input_o,
  output logic motor2_select_o,
  output logic run_o,
  output logic [3:0] speed_select_o
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic_cfg_s logic_cfg [NUM_LOGIC];
  logic [TIME_W-1:0] filt_time [NUM_INPUTS];
  logic [FUNC_W-1:0] func_sel [NUM_INPUTS];
  logic [TIME_W-1:0] speed_code_settle_time;

  // clamp time settings to the legal range
  function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] v);
    return (v > TIME_MAX) ? TIME_MAX : v;
  endfunction : clamp_time

  // logic output settings, three words each
  genvar g;
  generate
    for (g = 0; g < NUM_LOGIC; g++) begin : g_lcfg
      localparam logic [ADDR_W-1:0] BASE = A_LOGIC_BASE + ADDR_W'(3 * g);
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          logic_cfg[g] <= '{SEL_RESET, SEL_RESET, OP_AND};
        end else if (wr_i) begin
          if (addr_i == BASE) logic_cfg[g].opa <= wdata_i[SEL_W-1:0];
          if (addr_i == BASE + 8'h01) logic_cfg[g].opb <= wdata_i[SEL_W-1:0];
          // codes above xor are held off
          if (addr_i == BASE + 8'h02 && wdata_i[OPER_W-1:0] <= OP_XOR)
            logic_cfg[g].oper <= wdata_i[OPER_W-1:0];
        end
      end
    end
  endgenerate

  // per-input response time and function select
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : g_icfg
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          filt_time[g] <= FILTER_RESET;
          func_sel[g] <= FN_NONE;
        end else if (wr_i) begin
          if (addr_i == A_FILT_BASE + ADDR_W'(g))
            filt_time[g] <= clamp_time(wdata_i[TIME_W-1:0]);
          if (addr_i == A_FUNC_BASE + ADDR_W'(g))
            func_sel[g] <= wdata_i[FUNC_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) speed_code_settle_time <= SETTLE_RESET;
    else if (wr_i && addr_i == A_SETTLE)
      speed_code_settle_time <= clamp_time(wdata_i[TIME_W-1:0]);
  end

  // ----------------------------------------------------------------
  // input filtering
  // ----------------------------------------------------------------
  logic [NUM_INPUTS-1:0] filt;

  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : g_filt
      input_filter #(
        .UNIT_CYC(FILTER_CYC)
      ) u_filt (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .raw_i(term_i[g]),
        .units_i(filt_time[g]),
        .level_o(filt[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // function decode: OR of every input assigned a given code
  // ----------------------------------------------------------------
  function automatic logic func_active(input logic [FUNC_W-1:0] code,
                                       input logic [NUM_INPUTS-1:0] lv,
                                       input logic [FUNC_W-1:0] sel [NUM_INPUTS]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (sel[i] == code && lv[i]) hit = 1'b1;
    end
    return hit;
  endfunction : func_active

  drive_cmd_s next_cmd;
  assign next_cmd.run_fwd = func_active(FN_FWD, filt, func_sel);
  assign next_cmd.run_rev = func_active(FN_REV, filt, func_sel);
  assign next_cmd.jog = func_active(FN_JOG, filt, func_sel);
  assign next_cmd.dc_brake = func_active(FN_DCB, filt, func_sel);
  assign next_cmd.motor2 = func_active(FN_MOT2, filt, func_sel);
  generate
    for (g = 0; g < 4; g++) begin : g_spd
      assign next_cmd.speed_sel[g] =
        func_active(FN_SPD0 + FUNC_W'(g), filt, func_sel);
    end
  endgenerate

  // ----------------------------------------------------------------
  // speed code settle: raw code must hold the settle time
  // ----------------------------------------------------------------
  logic [3:0] spd_seen;
  logic [3:0] spd_accepted;
  logic [31:0] settle_cyc;
  logic [TIME_W-1:0] settle_units;
  wire settle_tick = (settle_cyc == 32'(SETTLE_CYC - 1));
  wire spd_pending = (next_cmd.speed_sel != spd_accepted);
  wire spd_moved = (next_cmd.speed_sel != spd_seen);
  wire spd_take = spd_pending && !spd_moved &&
                  (speed_code_settle_time == '0 ||
                   (settle_tick && settle_units + 8'h01 >= speed_code_settle_time));

  // a zero setting accepts one cycle after the code is seen
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spd_seen <= 4'h0;
      spd_accepted <= 4'h0;
      settle_cyc <= '0;
      settle_units <= '0;
    end else begin
      spd_seen <= next_cmd.speed_sel;
      if (spd_moved || !spd_pending || spd_take) begin
        settle_cyc <= '0; // any change restarts the wait
        settle_units <= '0;
      end else if (settle_tick) begin
        settle_cyc <= '0;
        settle_units <= settle_units + 8'h01;
      end else begin
        settle_cyc <= settle_cyc + 32'h1;
      end
      if (spd_take) spd_accepted <= spd_seen;
    end
  end

  // ----------------------------------------------------------------
  // logic outputs
  // ----------------------------------------------------------------
  logic [NUM_LOGIC-1:0] next_logic;

  generate
    for (g = 0; g < NUM_LOGIC; g++) begin : g_log
      logic_output u_log (
        .cfg_i(logic_cfg[g]),
        .dout_i(dout_func_i),
        .value_o(next_logic[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      logic_out_o <= '0;
      forward_run_input_o <= 1'b0;
      reverse_run_input_o <= 1'b0;
      jog_input_o <= 1'b0;
      external_dc_brake_input_o <= 1'b0;
      motor2_select_o <= 1'b0;
      run_o <= 1'b0;
      speed_select_o <= 4'h0;
    end else begin
      logic_out_o <= next_logic;
      forward_run_input_o <= next_cmd.run_fwd;
      reverse_run_input_o <= next_cmd.run_rev;
      jog_input_o <= next_cmd.jog;
      external_dc_brake_input_o <= next_cmd.dc_brake;
      motor2_select_o <= next_cmd.motor2;
      // stop mode unless one of the run sources is active
      run_o <= next_cmd.run_fwd | next_cmd.run_rev | next_cmd.jog;
      speed_select_o <= spd_accepted;
    end
  end

  // ----------------------------------------------------------------
  // register read, data valid one cycle after the strobe
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0; // unmapped addresses read zero
    for (int i = 0; i < NUM_LOGIC; i++) begin
      if (addr_i == A_LOGIC_BASE + ADDR_W'(3 * i))
        rd_mux = DATA_W'(logic_cfg[i].opa);
      if (addr_i == A_LOGIC_BASE + ADDR_W'(3 * i + 1))
        rd_mux = DATA_W'(logic_cfg[i].opb);
      if (addr_i == A_LOGIC_BASE + ADDR_W'(3 * i + 2))
        rd_mux = DATA_W'(logic_cfg[i].oper);
    end
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (addr_i == A_FILT_BASE + ADDR_W'(i)) rd_mux = DATA_W'(filt_time[i]);
      if (addr_i == A_FUNC_BASE + ADDR_W'(i)) rd_mux = DATA_W'(func_sel[i]);
    end
    if (addr_i == A_SETTLE) rd_mux = DATA_W'(speed_code_settle_time);
    if (addr_i == A_DOUT) rd_mux = DATA_W'(logic_out_o);
    if (addr_i == A_STATUS)
      rd_mux = DATA_W'({spd_accepted, run_o, motor2_select_o,
                        external_dc_brake_input_o, jog_input_o,
                        reverse_run_input_o, forward_run_input_o});
    if (addr_i == A_INPUTS) rd_mux = DATA_W'(filt);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= '0;
    else if (rd_i) rdata_o <= rd_mux;
    else rdata_o <= '0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // reference xor of output 0, formed apart from the output cell
  wire xor0_ref = dout_func_i[logic_cfg[0].opa] ^
                  dout_func_i[logic_cfg[0].opb];
  wire xor0_plain = (logic_cfg[0].opa < DO_LOG1) &&
                    (logic_cfg[0].opb < DO_LOG1);
  property p_xor_out;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (logic_cfg[0].oper == OP_XOR && xor0_plain) |=>
      logic_out_o[0] == $past(xor0_ref);
  endproperty
  a_xor_out: assert property (p_xor_out)
    else $error("logic output 0 lags its operator result");

  property p_barred;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (logic_cfg[1].opa == DO_NONE && logic_cfg[1].oper == OP_AND) |-> !next_logic[1];
  endproperty
  a_barred: assert property (p_barred)
    else $error("unassigned operand did not read as zero");

  property p_oper_legal;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    logic_cfg[2].oper <= OP_XOR;
  endproperty
  a_oper_legal: assert property (p_oper_legal)
    else $error("operator code out of range");

  property p_time_range;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    filt_time[0] <= TIME_MAX && speed_code_settle_time <= TIME_MAX;
  endproperty
  a_time_range: assert property (p_time_range)
    else $error("time setting above its range");

  property p_fwd;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    next_cmd.run_fwd |=> forward_run_input_o && run_o;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward input did not run the drive");

  property p_stop;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !(next_cmd.run_fwd || next_cmd.run_rev || next_cmd.jog) |=> !run_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("drive ran with no run input");

  property p_spd_stable;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $changed(spd_accepted) |-> $past(next_cmd.speed_sel, 2) == spd_accepted;
  endproperty
  a_spd_stable: assert property (p_spd_stable)
    else $error("speed code accepted before it settled");

  property p_spd_out;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 speed_select_o == $past(spd_accepted);
  endproperty
  a_spd_out: assert property (p_spd_out)
    else $error("speed select output not the accepted code");

endmodule : drive_terminal_logic
`default_nettype wire

// [hw/drive_terminal_pkg.sv]
// package: constants, codes and carriers of the drive terminal logic
package drive_terminal_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_INPUTS = 7;
  localparam int NUM_LOGIC = 3;
  localparam int NUM_DOUT_FUNCS = 32;
  localparam int SEL_W = 5;
  localparam int OPER_W = 2;
  localparam int FUNC_W = 5;
  localparam int TIME_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int FILTER_UNIT_MS = 2;
  localparam int SETTLE_UNIT_MS = 10;
  localparam int FILTER_UNIT_CYC = CLK_HZ / 1000 * FILTER_UNIT_MS;
  localparam int SETTLE_UNIT_CYC = CLK_HZ / 1000 * SETTLE_UNIT_MS;
  localparam logic [TIME_W-1:0] TIME_MAX = 8'hC8;
  localparam logic [TIME_W-1:0] FILTER_RESET = 8'h01;
  localparam logic [TIME_W-1:0] SETTLE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // operator and input function codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_AND = 2'h0,
    OP_OR = 2'h1,
    OP_XOR = 2'h2
  } logic_oper_e;

  localparam logic [FUNC_W-1:0] FN_FWD = 5'h00;
  localparam logic [FUNC_W-1:0] FN_REV = 5'h01;
  localparam logic [FUNC_W-1:0] FN_SPD0 = 5'h02;
  localparam logic [FUNC_W-1:0] FN_SPD3 = 5'h05;
  localparam logic [FUNC_W-1:0] FN_JOG = 5'h06;
  localparam logic [FUNC_W-1:0] FN_DCB = 5'h07;
  localparam logic [FUNC_W-1:0] FN_MOT2 = 5'h08;
  localparam logic [FUNC_W-1:0] FN_NONE = 5'h1F;

  // discrete-output codes barred as logic operands, then the operand reset code
  localparam logic [SEL_W-1:0] DO_LOG1 = 5'h1B;
  localparam logic [SEL_W-1:0] DO_LOG3 = 5'h1D;
  localparam logic [SEL_W-1:0] DO_OPTION = 5'h1E;
  localparam logic [SEL_W-1:0] DO_NONE = 5'h1F;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;

  // ----------------------------------------------------------------
  // register map (word index = address)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_LOGIC_BASE = 8'h00; // 3 per output
  localparam logic [ADDR_W-1:0] A_FILT_BASE = 8'h10;  // one per input
  localparam logic [ADDR_W-1:0] A_FUNC_BASE = 8'h20;  // one per input
  localparam logic [ADDR_W-1:0] A_SETTLE = 8'h30;
  localparam logic [ADDR_W-1:0] A_DOUT = 8'h31;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h32;
  localparam logic [ADDR_W-1:0] A_INPUTS = 8'h33;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0] opa;
    logic [SEL_W-1:0] opb;
    logic [OPER_W-1:0] oper;
  } logic_cfg_s;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic jog;
    logic dc_brake;
    logic motor2;
    logic [3:0] speed_sel;
  } drive_cmd_s;

endpackage : drive_terminal_pkg

// [hw/input_filter.sv]
// module: response-time filter of one input terminal
`timescale 1ns/1ps
`default_nettype none
module input_filter
  import drive_terminal_pkg::*;
#(
  parameter int UNIT_CYC = FILTER_UNIT_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // raw pin and setting
  input wire logic raw_i,
  input wire logic [TIME_W-1:0] units_i,
  // result
  output logic level_o
);

  // ----------------------------------------------------------------
  // three-stage synchroniser, change counted once stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] sync;
  logic agreed;
  logic [31:0] cyc;
  logic [TIME_W-1:0] units;
  wire stable = (sync[1] == sync[2]);
  wire differs = stable && (sync[2] != agreed);
  wire unit_tick = (cyc == 32'(UNIT_CYC - 1));
  wire done = differs && ((units_i == '0) || (unit_tick && units + 8'h01 >= units_i));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) sync <= 3'h0;
    else sync <= {sync[1:0], raw_i};
  end

  // new level held for the programmed time before it passes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      agreed <= 1'b0;
      cyc <= '0;
      units <= '0;
    end else if (!differs || done) begin
      cyc <= '0; // any bounce back restarts the wait
      units <= '0;
      if (done) agreed <= sync[2];
    end else if (unit_tick) begin
      cyc <= '0;
      units <= units + 8'h01;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end

  assign level_o = agreed;

endmodule : input_filter
`default_nettype wire

// [hw/logic_output.sv]
// module: one programmable logic output combining two discrete outputs
`timescale 1ns/1ps
`default_nettype none
module logic_output
  import drive_terminal_pkg::*;
(
  // configuration and sources
  input wire logic_cfg_s cfg_i,
  input wire logic [NUM_DOUT_FUNCS-1:0] dout_i,
  // result
  output logic value_o
);

  // barred operands read as zero
  function automatic logic pick(input logic [SEL_W-1:0] s,
                                input logic [NUM_DOUT_FUNCS-1:0] d);
    if ((s >= DO_LOG1 && s <= DO_LOG3) || s == DO_OPTION || s == DO_NONE)
      return 1'b0;
    return d[s];
  endfunction : pick

  wire opa = pick(cfg_i.opa, dout_i);
  wire opb = pick(cfg_i.opb, dout_i);

  // operator select
  assign value_o = (cfg_i.oper == OP_OR) ? (opa | opb) :
                   (cfg_i.oper == OP_XOR) ? (opa ^ opb) : (opa & opb);

endmodule : logic_output
`default_nettype wire

// [bench/term_model.sv]
// field wiring model driving the input terminals, with optional chatter
`timescale 1ns/1ps
`default_nettype none
module term_model
  import drive_terminal_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // wanted levels and chatter enable
  input wire logic [NUM_INPUTS-1:0] level_i,
  input wire logic bounce_i,
  // terminal wires
  output logic [NUM_INPUTS-1:0] term_o
);
  logic [NUM_INPUTS-1:0] now = '0;
  logic [NUM_INPUTS-1:0] was = '0;
  logic [2:0] left = 3'h0;
  // a chattering contact falls back every other cycle, so a filter that
  // does not restart its wait on each bounce lets a glitch through
  always @(posedge clk_sys_i) begin
    if (level_i != now) begin
      was <= now;
      now <= level_i;
      left <= bounce_i ? 3'h6 : 3'h0;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end
  assign term_o = left[0] ? was : now;
endmodule : term_model
`default_nettype wire

// [bench/drive_terminal_logic_tb_top.sv]
// testbench top of the drive terminal logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  failures++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module drive_terminal_logic_tb_top;
  import drive_terminal_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_d = 1'b0;
  logic bounce = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] q [$];
  logic [NUM_INPUTS-1:0] lvl = '0;
  logic [NUM_DOUT_FUNCS-1:0] dout = '0;
  logic [31:0] seed = 32'h00011A74;
  logic [4:0] ca [3] = '{5'h0, 5'h0, 5'h0};
  logic [4:0] cb [3] = '{5'h0, 5'h0, 5'h0};
  logic [1:0] co [3] = '{2'h0, 2'h0, 2'h0};
  logic [4:0] fn [5] = '{FN_FWD, FN_REV, FN_JOG, FN_DCB, FN_MOT2};
  logic [9:0] ex [5] = '{10'h021, 10'h022, 10'h024, 10'h008, 10'h010};
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  wire logic [DATA_W-1:0] rdata_o;
  wire logic [NUM_INPUTS-1:0] term;
  wire logic [NUM_LOGIC-1:0] lo;
  wire logic fwd, rev, jog, dcb, mot2, run;
  wire logic [3:0] spd;
  wire logic [9:0] stat = {spd, run, mot2, dcb, jog, rev, fwd};

  // short counts keep the filters and settle timer fast in simulation
  drive_terminal_logic #(.FILTER_CYC(4), .SETTLE_CYC(8)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .term_i(term), .dout_func_i(dout), .logic_out_o(lo),
    .forward_run_input_o(fwd), .reverse_run_input_o(rev),
    .jog_input_o(jog), .external_dc_brake_input_o(dcb),
    .motor2_select_o(mot2), .run_o(run), .speed_select_o(spd));

  term_model field (.clk_sys_i(clk_sys_i), .level_i(lvl),
    .bounce_i(bounce), .term_o(term));

  always #5 clk_sys_i = ~clk_sys_i;

  // -----------------------------------------------------------------
  // closing, timeout and read monitor
  // -----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ceiling is many times the few hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    rd_d <= rd_i;
    if (rd_d) begin
      `CHK("rdata", q[0], rdata_o)
      void'(q.pop_front());
    end
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // barred operand codes count as a low operand
  function automatic logic lop(input logic [1:0] o, input logic [4:0] a,
                               input logic [4:0] b);
    logic x, y;
    x = (a >= DO_LOG1) ? 1'b0 : dout[a];
    y = (b >= DO_LOG1) ? 1'b0 : dout[b];
    case (o)
      2'h0: return x & y;
      2'h1: return x | y;
      default: return x ^ y;
    endcase
  endfunction : lop

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : rd

  task automatic wait_stat(input logic [9:0] e);
    int i;
    for (i = 0; i < 80 && stat !== e; i++) @(posedge clk_sys_i);
    `CHK("status", e, stat)
  endtask : wait_stat

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    int i, k;
    logic [3:0] c, old;
    logic [2:0] lx;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (i = 0; i < 9; i++) rd(8'(i), 32'h0);
    for (i = 0; i < 7; i++) rd(A_FILT_BASE + 8'(i), 32'h1);
    rd(A_SETTLE, 32'h0);
    rd(8'h3F, 32'h0);
    wr(A_FILT_BASE + 8'h6, 32'hFA);
    rd(A_FILT_BASE + 8'h6, 32'hC8);
    wr(A_FILT_BASE + 8'h6, 32'h1);
    wr(A_SETTLE, 32'hFF);
    rd(A_SETTLE, 32'hC8);
    wr(A_SETTLE, 32'h1);
    $display("test reset and range done");
    // every output with every operator, random operands including barred
    for (k = 0; k < 9; k++) begin
      i = k / 3;
      ca[i] = 5'(rnd());
      cb[i] = 5'(rnd());
      if (k == 3) ca[i] = DO_NONE;
      co[i] = 2'(k % 3);
      wr(8'(3 * i), 32'(ca[i]));
      wr(8'(3 * i + 1), 32'(cb[i]));
      wr(8'(3 * i + 2), 32'(co[i]));
      dout <= rnd();
      repeat (2) @(posedge clk_sys_i);
      lx = {lop(co[2], ca[2], cb[2]), lop(co[1], ca[1], cb[1]),
        lop(co[0], ca[0], cb[0])};
      rd(A_DOUT, 32'(lx));
      `CHK("logic out", lx, lo)
    end
    wr(8'h2, 32'h3);
    rd(8'h2, 32'(co[0]));
    wr(8'h8, 32'h3);
    rd(8'h8, 32'(co[2]));
    $display("test logic outputs done");
    for (k = 0; k < 5; k++) begin
      wr(A_FUNC_BASE + 8'(k), 32'(fn[k]));
      lvl <= 7'(1 << k);
      wait_stat(ex[k]);
      rd(A_STATUS, 32'(ex[k]));
      lvl <= '0;
      wait_stat(10'h0);
      wr(A_FUNC_BASE + 8'(k), 32'(FN_NONE));
    end
    $display("test input decode done");
    // three steps of filter with a chattering contact
    wr(A_FUNC_BASE, 32'(FN_FWD));
    wr(A_FILT_BASE, 32'h3);
    bounce <= 1'b1;
    lvl <= 7'h01;
    repeat (16) @(posedge clk_sys_i);
    `CHK("filter early", 1'b0, fwd)
    wait_stat(10'h021);
    lvl <= 7'h00;
    wait_stat(10'h000);
    bounce <= 1'b0;
    $display("test filter timing done");
    for (k = 0; k < 4; k++) wr(A_FUNC_BASE + 8'(k + 3), 32'(FN_SPD0 + k));
    old = 4'h0;
    for (k = 0; k < 4; k++) begin
      c = 4'(rnd());
      if (c == old) c = ~old;
      lvl <= {c, 3'h0};
      repeat (14) @(posedge clk_sys_i);
      `CHK("speed early", old, spd)
      wait_stat({c, 6'h0});
      rd(A_STATUS, 32'({c, 6'h0}));
      old = c;
    end
    $display("test speed select done");
    report_and_stop();
  end
endmodule : drive_terminal_logic_tb_top
`default_nettype wire
